// file: dv/crf_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// protocol core stand-in feeding received frames
// ************************************************************
module crf_core_model
   import crf_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic busy,
   output logic hdr_valid,
   output crf_hdr_t hdr,
   output logic word_valid,
   output logic [31:0] word_data,
   output logic frame_end
);
   initial begin
      hdr_valid = 1'b0;
      hdr = '0;
      word_valid = 1'b0;
      word_data = 32'h0;
      frame_end = 1'b0;
   end

   task automatic send(input logic ext, input logic [28:0] id, input int n, input int gap,
                       input logic [31:0] base);
      int k;
      // a new header is offered only once the handler has gone idle
      while (busy !== 1'b0) begin
         @(posedge clk) #1;
      end
      hdr.ext = ext;
      hdr.id = id;
      // lengths of 5 to 7 bytes never occur: one word is 4 bytes, two are 8
      hdr.dlc = (n == 1) ? 4'h4 : ((n == 2) ? 4'h8 : 4'hF);
      hdr.words = 5'(n);
      hdr_valid = 1'b1;
      @(posedge clk) #1;
      hdr_valid = 1'b0;
      for (k = 0; k < n; k++) begin
         word_data = base + 32'(k) * 32'h9E3779B9;
         word_valid = 1'b1;
         @(posedge clk) #1;
         // back-to-back words keep the strobe up instead of dropping and raising it at once
         if (gap > 0 || k == n - 1) begin
            word_valid = 1'b0;
            // released data line shows the inverse, never a stale copy
            word_data = ~word_data;
            repeat (gap) @(posedge clk) #1;
         end
      end
      frame_end = 1'b1;
      @(posedge clk) #1;
      frame_end = 1'b0;
   endtask
endmodule
`default_nettype wire

// file: dv/tb_can_rx_acceptance_filter_store.sv
`timescale 1ns/1ps
`default_nettype none
`include "crf_defs.svh"
module tb_can_rx_acceptance_filter_store;
   import crf_pkg::*;
   logic clk, reset, hdr_valid, word_valid, frame_end, ram_wr_valid, fail_flag, busy;
   crf_hdr_t hdr;
   logic [31:0] word_data;
   crf_filter_t [`CRF_STD_FILTERS-1:0] std_filters;
   crf_filter_t [`CRF_EXT_FILTERS-1:0] ext_filters;
   crf_ram_wr_t ram_wr;
   crf_ram_wr_t e;
   crf_ram_wr_t q[$];
   logic [`CRF_FIFO_IDX_W-1:0] put_index, exp_pi;
   logic [`CRF_BUF_COUNT-1:0] nd_flags, exp_nd, new_data_clear;
   int n_mismatch, compares, cyc, t0, exp_lat, i, k;
   logic first;
   logic [31:0] seed;

   crf_rx_filter_store dut (.clk(clk), .reset(reset), .hdr_valid(hdr_valid), .hdr(hdr),
      .word_valid(word_valid), .word_data(word_data), .frame_end(frame_end),
      .std_filters(std_filters), .ext_filters(ext_filters), .ram_wr_valid(ram_wr_valid),
      .ram_wr(ram_wr), .rx_fifo_put_index(put_index), .rx_buffer_new_data_flag(nd_flags),
      .new_data_clear(new_data_clear), .message_ram_access_failure_flag(fail_flag),
      .busy(busy));
   crf_core_model core (.clk(clk), .reset(reset), .busy(busy), .hdr_valid(hdr_valid),
      .hdr(hdr), .word_valid(word_valid), .word_data(word_data), .frame_end(frame_end));

   // one 100 MHz clock serves host and kernel side alike, so neither outruns the other
   initial clk = 1'b0;
   always #5 clk = ~clk;

   task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic end_of_test();
      if (n_mismatch == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // ************************************************************
   // write monitor against the expected word queue
   // ************************************************************
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc > 20000) begin
         n_mismatch++;
         end_of_test();
      end
      if (hdr_valid === 1'b1 && busy === 1'b0) begin
         t0 = cyc;
         first = 1'b1;
      end
      if (ram_wr_valid === 1'b1) begin
         if (first) chk("first write latency", 64'(cyc - t0), 64'(exp_lat));
         first = 1'b0;
         if (q.size() == 0) begin
            chk("unexpected write", 64'h1, 64'h0);
         end else begin
            e = q.pop_front();
            chk("ram_wr", 64'(ram_wr), 64'(e));
         end
      end
   end

   task automatic run_frame(input logic ext, input int m, input int n, input int gap,
                            input logic tob, input logic [2:0] bi, input logic [28:0] id,
                            input logic hit, input logic [31:0] base);
      crf_filter_t f;
      crf_filter_t [7:0] own;
      crf_filter_t [7:0] other;
      f = '{enable: 1'b1, id: id ^ 29'h3, mask: 29'h1FFFFFFF, to_buffer: 1'b0, buf_idx: 3'h0};
      for (k = 0; k < 8; k++) begin
         own[k] = f;
         own[k].enable = hit;
         other[k] = f;
      end
      own[m].id = id;
      own[m].to_buffer = tob;
      own[m].buf_idx = bi;
      // a later matching element must lose to the first hit; a miss frame gets none
      if (m < 7 && hit) own[m + 1] = '{1'b1, id, 29'h1FFFFFFF, ~tob, bi + 3'h1};
      other[0] = '{1'b1, id, 29'h1FFFFFFF, 1'b1, ~bi};
      std_filters = ext ? other : own;
      ext_filters = ext ? own : other;
      exp_lat = 2 + (ext ? 2 : 1) * (m + 1);
      if (hit) begin
         for (k = 0; k < n && k < 16; k++) begin
            q.push_back('{tob, bi, 5'(2 + k), base + 32'(k) * 32'h9E3779B9});
         end
         if (tob) exp_nd[bi] = 1'b1;
         else exp_pi = exp_pi + 3'h1;
      end
      core.send(ext, id, n, gap, base);
      for (k = 0; k < 200 && busy !== 1'b0; k++) @(posedge clk) #1;
      @(posedge clk) #1;
      chk("writes left", 64'(q.size()), 64'h0);
      chk("put index", 64'(put_index), 64'(exp_pi));
      chk("new data flags", 64'(nd_flags), 64'(exp_nd));
      chk("access failure flag", 64'(fail_flag), 64'h0);
      new_data_clear = exp_nd;
      exp_nd = 8'h00;
      @(posedge clk) #1;
      new_data_clear = 8'h00;
      chk("flags cleared", 64'(nd_flags), 64'h0);
   endtask

   initial begin
      reset = 1'b1;
      std_filters = '0;
      ext_filters = '0;
      new_data_clear = 8'h00;
      n_mismatch = 0;
      compares = 0;
      cyc = 0;
      first = 1'b0;
      exp_pi = 3'h0;
      exp_nd = 8'h00;
      seed = 32'h3DA5;
      repeat (2) @(posedge clk);
      #1 reset = 1'b0;
      for (i = 0; i < 30; i++) begin
         // one frame in three paces its words; the rest come back to back
         run_frame(1'($random(seed)), (i < 2) ? 7 * i : int'($unsigned($random(seed)) % 8),
                   (i == 5) ? 17 : 1 + int'($unsigned($random(seed)) % 16),
                   (i % 3 == 0) ? 2 : 0, 1'($random(seed)), 3'($random(seed)),
                   (i % 2 == 0) ? 29'($random(seed)) : 29'($random(seed)) & 29'h7FF,
                   (i != 7), $random(seed));
      end
      end_of_test();
   end
endmodule
`default_nettype wire

// file: rtl/crf_rx_filter_store.sv
`timescale 1ns/1ps
`default_nettype none
`include "crf_defs.svh"
module crf_rx_filter_store
   import crf_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic hdr_valid,
   input wire crf_hdr_t hdr,
   input wire logic word_valid,
   input wire logic [31:0] word_data,
   input wire logic frame_end,
   input wire crf_filter_t [`CRF_STD_FILTERS-1:0] std_filters,
   input wire crf_filter_t [`CRF_EXT_FILTERS-1:0] ext_filters,
   output logic ram_wr_valid,
   output crf_ram_wr_t ram_wr,
   output logic [`CRF_FIFO_IDX_W-1:0] rx_fifo_put_index,
   output logic [`CRF_BUF_COUNT-1:0] rx_buffer_new_data_flag,
   input wire logic [`CRF_BUF_COUNT-1:0] new_data_clear,
   output logic message_ram_access_failure_flag,
   output logic busy
);
   crf_state_t state;
   crf_hdr_t cur;
   logic [3:0] elem;
   logic [2:0] eval_cnt;
   logic match_to_buf;
   logic [`CRF_BUF_IDX_W-1:0] match_buf;
   logic [4:0] rx_count;
   logic [4:0] st_count;
   logic frame_ended;
   logic [31:0] cache_rd;
   crf_filter_t cur_flt;
   logic elem_hit;
   logic last_elem;
   logic [2:0] eval_need;
   logic commit;

   // ************************************************************
   // filter element compare
   // ************************************************************
   always_comb begin
      cur_flt = '0;
      // only the list of the frame's own id format is looked at
      if (cur.ext) begin
         cur_flt = ext_filters[elem[`CRF_EXT_IDX_W-1:0]];
         last_elem = (elem == 4'(`CRF_EXT_FILTERS - 1));
         eval_need = `CRF_EXT_EVAL_CYC;
         elem_hit = cur_flt.enable && (((cur.id ^ cur_flt.id) & cur_flt.mask) == 29'h0);
      end else begin
         cur_flt = std_filters[elem[`CRF_STD_IDX_W-1:0]];
         last_elem = (elem == 4'(`CRF_STD_FILTERS - 1));
         eval_need = `CRF_STD_EVAL_CYC;
         elem_hit = cur_flt.enable &&
            (((cur.id[10:0] ^ cur_flt.id[10:0]) & cur_flt.mask[10:0]) == 11'h0);
      end
   end

   // ************************************************************
   // sequencer
   // ************************************************************
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state <= CRF_IDLE;
         cur <= '0;
         elem <= 4'h0;
         eval_cnt <= 3'h0;
         match_to_buf <= 1'b0;
         match_buf <= '0;
      end else begin
         unique case (state)
            CRF_IDLE: begin
               if (hdr_valid) begin
                  cur <= hdr;
                  elem <= 4'h0;
                  eval_cnt <= 3'h1;
                  state <= CRF_SEARCH;
               end
            end
            CRF_SEARCH: begin
               if (eval_cnt != eval_need) begin
                  eval_cnt <= eval_cnt + 3'h1;
               end else if (elem_hit) begin
                  // first hit ends the walk
                  match_to_buf <= cur_flt.to_buffer;
                  match_buf <= cur_flt.buf_idx;
                  state <= CRF_STORE;
               end else if (last_elem) begin
                  state <= CRF_DROP;
               end else begin
                  elem <= elem + 4'h1;
                  eval_cnt <= 3'h1;
               end
            end
            CRF_STORE: begin
               if (frame_ended && st_count == rx_count && !commit) begin
                  state <= CRF_DONE;
               end
            end
            CRF_DONE: begin
               state <= CRF_IDLE;
            end
            CRF_DROP: begin
               if (frame_ended) begin
                  state <= CRF_IDLE;
               end
            end
            default: begin
               state <= CRF_IDLE;
            end
         endcase
      end
   end

   // ************************************************************
   // payload cache fill and commit
   // ************************************************************
   // the cache is filled while the search still runs; nothing leaves it
   // before a match is known
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rx_count <= 5'h00;
         frame_ended <= 1'b0;
      end else if (state == CRF_IDLE) begin
         rx_count <= 5'h00;
         frame_ended <= 1'b0;
      end else begin
         if (word_valid && rx_count != 5'(`CRF_MAX_WORDS)) begin
            rx_count <= rx_count + 5'h01;
         end
         if (frame_end) begin
            frame_ended <= 1'b1;
         end
      end
   end

   assign commit = (state == CRF_STORE) && (st_count != rx_count);
   assign busy = (state != CRF_IDLE);

   crf_word_cache u_cache (
      .clk(clk),
      .reset(reset),
      .wr_en(word_valid && state != CRF_IDLE && rx_count != 5'(`CRF_MAX_WORDS)),
      .wr_idx(rx_count[`CRF_WORD_IDX_W-1:0]),
      .wr_data(word_data),
      .rd_idx(st_count[`CRF_WORD_IDX_W-1:0]),
      .rd_data(cache_rd)
   );

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         st_count <= 5'h00;
         ram_wr_valid <= 1'b0;
         ram_wr <= '0;
      end else begin
         ram_wr_valid <= commit;
         if (state == CRF_IDLE) begin
            st_count <= 5'h00;
         end else if (commit) begin
            st_count <= st_count + 5'h01;
            ram_wr.to_buffer <= match_to_buf;
            ram_wr.buf_idx <= match_buf;
            ram_wr.word_addr <= `CRF_FIRST_WORD + st_count;
            ram_wr.data <= cache_rd;
         end
      end
   end

   // ************************************************************
   // frame report to host
   // ************************************************************
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rx_fifo_put_index <= '0;
         message_ram_access_failure_flag <= 1'b0;
      end else if (state == CRF_DONE && !match_to_buf) begin
         rx_fifo_put_index <= rx_fifo_put_index + 3'h1;
      end
   end

   genvar g;
   generate
      for (g = 0; g < `CRF_BUF_COUNT; g++) begin : g_nd
         // set wins over a clear in the same cycle
         always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
               rx_buffer_new_data_flag[g] <= 1'b0;
            end else if (state == CRF_DONE && match_to_buf && match_buf == 3'(g)) begin
               rx_buffer_new_data_flag[g] <= 1'b1;
            end else if (new_data_clear[g]) begin
               rx_buffer_new_data_flag[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // ************************************************************
   // checks
   // ************************************************************
   property p_start_at_zero;
      @(posedge clk) disable iff (reset)
      (state == CRF_IDLE && hdr_valid) |=> (state == CRF_SEARCH && elem == 4'h0);
   endproperty
   a_start_at_zero: assert property (p_start_at_zero) else $error("search not at element 0");

   property p_stop_first;
      @(posedge clk) disable iff (reset)
      (state == CRF_SEARCH && eval_cnt == eval_need && elem_hit) |=>
         (state == CRF_STORE && $stable(elem));
   endproperty
   a_stop_first: assert property (p_stop_first) else $error("search passed a hit");

   property p_step_up;
      @(posedge clk) disable iff (reset)
      (state == CRF_SEARCH && $past(state) == CRF_SEARCH && elem != $past(elem)) |->
         (elem == $past(elem) + 4'h1);
   endproperty
   a_step_up: assert property (p_step_up) else $error("element order broken");

   property p_ext_double;
      @(posedge clk) disable iff (reset)
      (state == CRF_SEARCH && cur.ext && eval_cnt == 3'h1) |=> $stable(elem);
   endproperty
   a_ext_double: assert property (p_ext_double) else $error("extended element too fast");

   property p_no_early_write;
      @(posedge clk) disable iff (reset)
      ram_wr_valid |-> $past(state) == CRF_STORE;
   endproperty
   a_no_early_write: assert property (p_no_early_write) else $error("write before filter end");

   property p_addr_range;
      @(posedge clk) disable iff (reset)
      ram_wr_valid |-> (ram_wr.word_addr >= `CRF_FIRST_WORD && ram_wr.word_addr <= `CRF_LAST_WORD);
   endproperty
   a_addr_range: assert property (p_addr_range) else $error("word address out of range");

   property p_fifo_bump;
      @(posedge clk) disable iff (reset)
      (state == CRF_DONE && !match_to_buf) |=>
         rx_fifo_put_index == $past(rx_fifo_put_index) + 3'h1;
   endproperty
   a_fifo_bump: assert property (p_fifo_bump) else $error("put index not advanced");

   property p_drop_no_write;
      @(posedge clk) disable iff (reset)
      (state == CRF_DROP) |=> !ram_wr_valid;
   endproperty
   a_drop_no_write: assert property (p_drop_no_write) else $error("rejected frame stored");

   property p_data_order;
      @(posedge clk) disable iff (reset)
      (ram_wr_valid && $past(ram_wr_valid, 2) && $past(state, 2) == CRF_STORE) |->
         ram_wr.word_addr == $past(ram_wr.word_addr) + 5'h01;
   endproperty
   a_data_order: assert property (p_data_order) else $error("stored word repeated");
endmodule
`default_nettype wire

// file: rtl/crf_word_cache.sv
`timescale 1ns/1ps
`default_nettype none
`include "crf_defs.svh"
// ************************************************************
// payload word cache with write-through read
// ************************************************************
module crf_word_cache
   import crf_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic wr_en,
   input wire logic [`CRF_WORD_IDX_W-1:0] wr_idx,
   input wire logic [31:0] wr_data,
   input wire logic [`CRF_WORD_IDX_W-1:0] rd_idx,
   output logic [31:0] rd_data
);
   logic [31:0] mem [0:`CRF_MAX_WORDS-1];
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_idx] <= wr_data;
      end
   end
   // read is addressed per word index, so a write to i+1 in the same cycle
   // cannot alias onto the word i being read out
   always_comb begin
      if (wr_en && wr_idx == rd_idx) begin
         rd_data = wr_data;
      end else begin
         rd_data = mem[rd_idx];
      end
   end
endmodule
`default_nettype wire

// file: shared/crf_defs.svh
`ifndef CRF_DEFS_SVH
`define CRF_DEFS_SVH
// ************************************************************
// sizes and timing of the receive filter and store path
// ************************************************************
`define CRF_STD_FILTERS 8
`define CRF_EXT_FILTERS 8
`define CRF_STD_IDX_W 3
`define CRF_EXT_IDX_W 3
`define CRF_STD_EVAL_CYC 3'h1
`define CRF_EXT_EVAL_CYC 3'h2
`define CRF_MAX_WORDS 16
`define CRF_WORD_IDX_W 4
`define CRF_FIRST_WORD 5'h02
`define CRF_LAST_WORD 5'h11
`define CRF_HOST_CLK_MAX_MHZ 100
`define CRF_FIFO_IDX_W 3
`define CRF_BUF_COUNT 8
`define CRF_BUF_IDX_W 3
`endif

// file: shared/crf_pkg.sv
`include "crf_defs.svh"
package crf_pkg;
   // received frame header from the protocol core
   typedef struct packed {
      logic ext;
      logic [28:0] id;
      logic [3:0] dlc;
      logic [4:0] words;
   } crf_hdr_t;
   // one filter element: id/mask with target
   typedef struct packed {
      logic enable;
      logic [28:0] id;
      logic [28:0] mask;
      logic to_buffer;
      logic [`CRF_BUF_IDX_W-1:0] buf_idx;
   } crf_filter_t;
   typedef struct packed {
      logic to_buffer;
      logic [`CRF_BUF_IDX_W-1:0] buf_idx;
      logic [4:0] word_addr;
      logic [31:0] data;
   } crf_ram_wr_t;
   typedef enum logic [2:0] {
      CRF_IDLE = 3'h0,
      CRF_SEARCH = 3'h1,
      CRF_STORE = 3'h3,
      CRF_DONE = 3'h2,
      CRF_DROP = 3'h6
   } crf_state_t;
endpackage
